// ===== hdl/rwd_pkg.sv
package rwd_pkg;
  // matrix geometry
  localparam int RWD_ROWS = 12;
  localparam int RWD_COLS = 11;
  localparam int RWD_CODE_W = 4;
  localparam int RWD_WORD_W = 15;
  localparam int RWD_IDX_W = 4;
  // word layout, index 0 is word bit 1
  localparam int RWD_CODE_LSB = 11;
  localparam int RWD_SIGN_COL = 10;
  localparam int RWD_DIGIT_W = 5;
  localparam int RWD_HI_LSB = 5;
  localparam int RWD_LO_LSB = 0;
  // row codes
  localparam logic [3:0] RWD_CODE_OFF = 4'h0;
  localparam logic [3:0] RWD_CODE_ROW1 = 4'h1;
  localparam logic [3:0] RWD_CODE_LAST_DIGIT_ROW = 4'hB;
  localparam logic [3:0] RWD_CODE_LAMP_ROW = 4'hC;
  localparam logic [3:0] RWD_LAMP_ROW = 4'hB;
  // lamp row columns
  localparam int RWD_COL_PROGRAM = 8;
  localparam int RWD_COL_TRACKER = 7;
  localparam int RWD_COL_GIMBAL = 5;
  localparam int RWD_COL_NO_ATT = 3;
  localparam logic [10:0] RWD_CAUTION_MASK = 11'h1A0;
  // display population
  localparam int RWD_DIGIT_POSITIONS = 24;
  localparam int RWD_NUMERIC_POSITIONS = 21;
  localparam int RWD_SIGN_POSITIONS = 3;
  localparam int RWD_INDICATORS = 15;
  // register map, byte addresses
  localparam logic [7:0] RWD_REG_CTRL = 8'h00;
  localparam logic [7:0] RWD_REG_STATUS = 8'h04;
  localparam logic [7:0] RWD_REG_MASK = 8'h08;
  localparam logic [7:0] RWD_REG_WORD = 8'h0C;
  localparam logic [7:0] RWD_REG_DIGITS = 8'h10;
  localparam logic [7:0] RWD_REG_ROW_BASE = 8'h40;
  localparam logic [31:0] RWD_CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] RWD_MASK_RST = 32'h0000_0000;
  // event bits
  localparam int RWD_EV_W = 4;
  localparam int RWD_EV_UPDATE = 0;
  localparam int RWD_EV_BAD_CODE = 1;
  localparam int RWD_EV_LAMP_RESET = 2;
  localparam int RWD_EV_CAUTION = 3;
endpackage : rwd_pkg

// ===== hdl/rwd_relay_decoder.sv
`timescale 1ns/1ps
module rwd_relay_decoder (
  input wire logic sys_clk_i, // 100 MHz system clock
  input wire logic resetn_i, // synchronous reset, active low
  input wire logic [1:0] row_code_input_high_n_i, // word bits 15-14, inverted
  input wire logic [1:0] row_code_input_low_n_i, // word bits 13-12, inverted
  input wire logic sign_column_input_n_i, // word bit 11, inverted
  input wire logic [9:0] digit_column_n_i, // word bits 10-1, inverted
  input wire logic lamp_reset_key_i, // hard-wired reset discrete
  input wire logic lamp_reset_code_i, // reset keycode seen, same clock
  input wire logic operator_error_req_i, // error lamp request
  input wire logic temp_req_i, // temperature caution request
  input wire logic restart_req_i, // restart caution request
  input wire logic [7:0] addr_i, // register byte address
  input wire logic [31:0] wr_data_i, // register write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [31:0] rd_data_o, // read data, cycle after strobe
  output logic irq_o, // level interrupt
  output logic [131:0] relay_matrix_o, // all relay states, row-major
  output logic [11:0] sign_relays_o, // sign column of each row
  output logic program_lamp_o, // program caution lamp
  output logic tracker_lamp_o, // tracker caution lamp
  output logic gimbal_lock_lamp_o, // gimbal lock caution lamp
  output logic no_attitude_lamp_o, // no attitude lamp
  output logic operator_error_lamp_o, // operator error lamp
  output logic temp_lamp_o, // temperature lamp
  output logic restart_lamp_o, // restart lamp
  output logic navigation_caution_output_o // caution to navigation system
);
  localparam int NR = rwd_pkg::RWD_ROWS;
  localparam int NC = rwd_pkg::RWD_COLS;
  localparam int WW = rwd_pkg::RWD_WORD_W;
  localparam int DW = rwd_pkg::RWD_DIGIT_W;
  localparam int LR = 11;

  // digit field of a column word
  function automatic logic [DW-1:0] digit_of(input logic [NC-1:0] cols, input logic hi);
    digit_of = hi ? cols[rwd_pkg::RWD_HI_LSB +: DW] : cols[rwd_pkg::RWD_LO_LSB +: DW];
  endfunction : digit_of

  logic [WW-1:0] word_n_sync;
  logic [WW-1:0] word_q;
  logic lrst_sync;
  logic [NC-1:0] col_w;
  logic wr_go;
  logic lamp_clear;
  logic lamp_clear_d_reg;
  logic [NC-1:0] relay_reg [NR];
  logic [31:0] ctrl_reg;
  logic [rwd_pkg::RWD_EV_W-1:0] status_reg;
  logic [rwd_pkg::RWD_EV_W-1:0] mask_reg;
  logic [rwd_pkg::RWD_EV_W-1:0] ev_set;
  logic [rwd_pkg::RWD_EV_W-1:0] w1c;
  logic [rwd_pkg::RWD_IDX_W-1:0] last_idx_reg;
  logic [NC-1:0] last_col_reg;
  logic last_go_reg;
  logic caution_next;
  logic supp_opr_reg;
  logic supp_temp_reg;
  logic supp_rst_reg;
  logic [7:0] row_off;
  logic [31:0] rd_next;

  // pins cross into the clock domain
  rwd_sync #(.W(WW), .RST_VAL('1)) u_word_sync (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .d_i({row_code_input_high_n_i, row_code_input_low_n_i, sign_column_input_n_i,
          digit_column_n_i}),
    .q_o(word_n_sync)
  );

  rwd_sync #(.W(1), .RST_VAL(1'b0)) u_lrst_sync (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .d_i(lamp_reset_key_i),
    .q_o(lrst_sync)
  );

  // undo the interface inversion
  assign word_q = ~word_n_sync;
  assign col_w = word_q[NC-1:0];

  // row decode
  rwd_row_if rif ();
  assign rif.code = word_q[rwd_pkg::RWD_CODE_LSB +: rwd_pkg::RWD_CODE_W];
  rwd_row_dec u_dec (
    .rif(rif.dec)
  );

  // matrix writes only with supply on and enabled
  assign wr_go = ctrl_reg[0] && rif.supply_on && !rif.bad_code;
  assign lamp_clear = lrst_sync || lamp_reset_code_i;

  // latching relay matrix, written on coincidence; lamp reset also clears the lamp row's caution relays
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      for (int r = 0; r < NR; r++) begin
        relay_reg[r] <= '0;
      end
    end else begin
      for (int r = 0; r < NR; r++) begin
        if (wr_go && rif.sel[r]) begin
          relay_reg[r] <= col_w;
        end else if (r == LR && lamp_clear) begin
          relay_reg[r] <= relay_reg[r] & ~rwd_pkg::RWD_CAUTION_MASK;
        end
      end
    end
  end

  // flatten relay state and sign column
  always_comb begin
    for (int r = 0; r < NR; r++) begin
      relay_matrix_o[r*NC +: NC] = relay_reg[r];
      sign_relays_o[r] = relay_reg[r][rwd_pkg::RWD_SIGN_COL];
    end
  end

  // lamp row drives indicators and caution output
  assign caution_next = |(relay_reg[LR] & rwd_pkg::RWD_CAUTION_MASK);
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      program_lamp_o <= 1'b0;
      tracker_lamp_o <= 1'b0;
      gimbal_lock_lamp_o <= 1'b0;
      no_attitude_lamp_o <= 1'b0;
      navigation_caution_output_o <= 1'b0;
    end else begin
      program_lamp_o <= relay_reg[LR][rwd_pkg::RWD_COL_PROGRAM];
      tracker_lamp_o <= relay_reg[LR][rwd_pkg::RWD_COL_TRACKER];
      gimbal_lock_lamp_o <= relay_reg[LR][rwd_pkg::RWD_COL_GIMBAL];
      no_attitude_lamp_o <= relay_reg[LR][rwd_pkg::RWD_COL_NO_ATT];
      navigation_caution_output_o <= caution_next;
    end
  end

  // reset key darkens status lamps until request drops
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      supp_opr_reg <= 1'b0;
      supp_temp_reg <= 1'b0;
      supp_rst_reg <= 1'b0;
      operator_error_lamp_o <= 1'b0;
      temp_lamp_o <= 1'b0;
      restart_lamp_o <= 1'b0;
    end else begin
      supp_opr_reg <= lamp_clear || (supp_opr_reg && operator_error_req_i);
      supp_temp_reg <= lamp_clear || (supp_temp_reg && temp_req_i);
      supp_rst_reg <= lamp_clear || (supp_rst_reg && restart_req_i);
      operator_error_lamp_o <= operator_error_req_i && !lamp_clear && !supp_opr_reg;
      temp_lamp_o <= temp_req_i && !lamp_clear && !supp_temp_reg;
      restart_lamp_o <= restart_req_i && !lamp_clear && !supp_rst_reg;
    end
  end

  // last row written, shown in the digits register
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      last_go_reg <= 1'b0;
      last_idx_reg <= '0;
      last_col_reg <= '0;
      lamp_clear_d_reg <= 1'b0;
    end else begin
      last_go_reg <= wr_go;
      lamp_clear_d_reg <= lamp_clear;
      if (wr_go) begin
        last_idx_reg <= rif.idx;
        last_col_reg <= col_w;
      end
    end
  end

  // events into sticky status
  always_comb begin
    ev_set = '0;
    ev_set[rwd_pkg::RWD_EV_UPDATE] = wr_go;
    ev_set[rwd_pkg::RWD_EV_BAD_CODE] = rif.bad_code;
    ev_set[rwd_pkg::RWD_EV_LAMP_RESET] = lamp_clear && !lamp_clear_d_reg;
    ev_set[rwd_pkg::RWD_EV_CAUTION] = caution_next && !navigation_caution_output_o;
    w1c = '0;
    if (wr_i && addr_i == rwd_pkg::RWD_REG_STATUS) begin
      w1c = wr_data_i[rwd_pkg::RWD_EV_W-1:0];
    end
  end

  // control, status and mask registers; set wins over clear
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      ctrl_reg <= rwd_pkg::RWD_CTRL_RST;
      status_reg <= '0;
      mask_reg <= rwd_pkg::RWD_MASK_RST[rwd_pkg::RWD_EV_W-1:0];
    end else begin
      status_reg <= (status_reg & ~w1c) | ev_set;
      if (wr_i && addr_i == rwd_pkg::RWD_REG_CTRL) begin
        ctrl_reg <= {31'h0, wr_data_i[0]};
      end
      if (wr_i && addr_i == rwd_pkg::RWD_REG_MASK) begin
        mask_reg <= wr_data_i[rwd_pkg::RWD_EV_W-1:0];
      end
    end
  end

  assign irq_o = |(status_reg & mask_reg);

  // read mux, unmapped reads as zero
  assign row_off = addr_i - rwd_pkg::RWD_REG_ROW_BASE;
  always_comb begin
    rd_next = 32'h0;
    if (addr_i == rwd_pkg::RWD_REG_CTRL) begin
      rd_next = ctrl_reg;
    end else if (addr_i == rwd_pkg::RWD_REG_STATUS) begin
      rd_next = {28'h0, status_reg};
    end else if (addr_i == rwd_pkg::RWD_REG_MASK) begin
      rd_next = {28'h0, mask_reg};
    end else if (addr_i == rwd_pkg::RWD_REG_WORD) begin
      rd_next = {17'h0, word_q};
    end else if (addr_i == rwd_pkg::RWD_REG_DIGITS) begin
      rd_next = {16'h0, last_idx_reg, 1'b0, last_col_reg[rwd_pkg::RWD_SIGN_COL],
                 digit_of(last_col_reg, 1'b1), digit_of(last_col_reg, 1'b0)};
    end else if (addr_i >= rwd_pkg::RWD_REG_ROW_BASE && row_off[1:0] == 2'h0
                 && row_off[7:2] < 6'(NR)) begin
      rd_next = {21'h0, relay_reg[row_off[5:2]]};
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      rd_data_o <= 32'h0;
    end else begin
      rd_data_o <= rd_i ? rd_next : 32'h0;
    end
  end

  // checks on the design's own behaviour
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  property p_row_onehot;
    rif.supply_on && !rif.bad_code |-> $onehot(rif.sel);
  endproperty
  a_row_onehot: assert property (p_row_onehot)
    else $error("valid row code did not select exactly one row");

  property p_row1;
    word_q[14:11] == rwd_pkg::RWD_CODE_ROW1 |-> rif.sel == 12'h001 && rif.idx == 4'h0;
  endproperty
  a_row1: assert property (p_row1)
    else $error("code 0001 did not select the first row");

  property p_supply_off;
    word_q[14:11] == 4'h0 |-> !rif.supply_on && rif.sel == 12'h000 && !wr_go;
  endproperty
  a_supply_off: assert property (p_supply_off)
    else $error("row supply active with zero row code");

  property p_inverted;
    $past(resetn_i) && $past(resetn_i, 2) |->
      word_q == ~$past({row_code_input_high_n_i, row_code_input_low_n_i,
                        sign_column_input_n_i, digit_column_n_i}, 2);
  endproperty
  a_inverted: assert property (p_inverted)
    else $error("word is not the inverted pins two cycles late");

  property p_load;
    last_go_reg |-> relay_reg[last_idx_reg] == last_col_reg;
  endproperty
  a_load: assert property (p_load)
    else $error("selected row did not take the column word");

  genvar gr;
  generate
    for (gr = 0; gr < NR; gr++) begin : g_hold
      property p_hold;
        !(wr_go && rif.sel[gr]) && !(gr == LR && lamp_clear) |=> $stable(relay_reg[gr]);
      endproperty
      a_hold: assert property (p_hold)
        else $error("unselected relay row changed");
    end
  endgenerate

  property p_sign;
    wr_go && col_w[rwd_pkg::RWD_SIGN_COL] |=> sign_relays_o[last_idx_reg];
  endproperty
  a_sign: assert property (p_sign)
    else $error("bit 11 did not set the sign relay");

  sequence s_lamp_row_caution;
    wr_go && rif.sel[LR] && |(col_w & rwd_pkg::RWD_CAUTION_MASK) && !lamp_clear;
  endsequence
  property p_caution;
    s_lamp_row_caution ##1 !lamp_clear |=> navigation_caution_output_o;
  endproperty
  a_caution: assert property (p_caution)
    else $error("lamp row caution relay did not raise caution output");

  sequence s_reset_pressed;
    lamp_clear && !(wr_go && rif.sel[LR]);
  endsequence
  property p_lamp_reset;
    s_reset_pressed ##1 !(wr_go && rif.sel[LR]) |=> !navigation_caution_output_o
      && !operator_error_lamp_o;
  endproperty
  a_lamp_reset: assert property (p_lamp_reset)
    else $error("lamp reset left caution or error lamp lit");

  property p_reset_clear;
    disable iff (1'b0) !resetn_i |=> relay_matrix_o == 132'h0;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("relay matrix not cleared by reset");

  // columns come straight from word bits 11-1
  property p_columns;
    wr_go |=> relay_reg[last_idx_reg] == $past(word_q[NC-1:0]);
  endproperty
  a_columns: assert property (p_columns)
    else $error("relay row did not take word bits 11 to 1");

  // lamp reset spares the no-attitude relay
  property p_noatt_kept;
    lamp_clear && !(wr_go && rif.sel[LR])
      |=> $stable(relay_reg[LR][rwd_pkg::RWD_COL_NO_ATT]);
  endproperty
  a_noatt_kept: assert property (p_noatt_kept)
    else $error("lamp reset changed the no-attitude relay");
endmodule : rwd_relay_decoder

// ===== hdl/rwd_row_dec.sv
`timescale 1ns/1ps
module rwd_row_dec (
  rwd_row_if.dec rif // code in, row select out
);
  // diode matrix: one row per valid code
  always_comb begin
    rif.sel = '0;
    rif.idx = '0;
    rif.supply_on = 1'b0;
    rif.bad_code = 1'b0;
    if (rif.code != rwd_pkg::RWD_CODE_OFF) begin
      rif.supply_on = 1'b1;
      if (rif.code <= rwd_pkg::RWD_CODE_LAST_DIGIT_ROW) begin
        rif.idx = rif.code - rwd_pkg::RWD_CODE_ROW1;
        rif.sel[rif.idx] = 1'b1;
      end else if (rif.code == rwd_pkg::RWD_CODE_LAMP_ROW) begin
        rif.idx = rwd_pkg::RWD_LAMP_ROW;
        rif.sel[rif.idx] = 1'b1;
      end else begin
        rif.bad_code = 1'b1;
      end
    end
  end
endmodule : rwd_row_dec

// ===== hdl/rwd_row_if.sv
`timescale 1ns/1ps
// row code in, one-hot row select out
interface rwd_row_if;
  logic [rwd_pkg::RWD_CODE_W-1:0] code;
  logic [rwd_pkg::RWD_ROWS-1:0] sel;
  logic [rwd_pkg::RWD_IDX_W-1:0] idx;
  logic supply_on;
  logic bad_code;
  modport dec (input code, output sel, output idx, output supply_on, output bad_code);
  modport user (output code, input sel, input idx, input supply_on, input bad_code);
endinterface : rwd_row_if

// ===== hdl/rwd_sync.sv
`timescale 1ns/1ps
module rwd_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic sys_clk_i, // system clock
  input wire logic resetn_i, // synchronous reset, active low
  input wire logic [W-1:0] d_i, // asynchronous level
  output logic [W-1:0] q_o // synchronised level
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // two flops, first read only by second
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;
endmodule : rwd_sync

// ===== testbench/rwd_word_src.sv
`timescale 1ns/1ps
// output channel of the computer, drives the inverted word pins
module rwd_word_src (
  input wire logic sys_clk_i, // system clock
  input wire logic [14:0] word_i, // word bits 15..1, active high
  input wire logic valid_i, // word presented while high
  output logic [1:0] row_hi_n_o, // word bits 15-14, inverted
  output logic [1:0] row_lo_n_o, // word bits 13-12, inverted
  output logic sign_n_o, // word bit 11, inverted
  output logic [9:0] digit_n_o // word bits 10-1, inverted
);
  // each active bit leaves as a low level; an idle channel holds every pin high
  always_ff @(posedge sys_clk_i) begin
    {row_hi_n_o, row_lo_n_o, sign_n_o, digit_n_o} <= valid_i ? ~word_i : 15'h7FFF;
  end
endmodule : rwd_word_src

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`define rwd_chk(got, exp) begin check_count++; if ((got) !== (exp)) begin errors++; \
  $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_top;
  logic sys_clk_i, resetn_i, valid, key, code_seen, err_req, temp_req, rst_req, wr, rd;
  logic [14:0] word;
  logic [1:0] hi_n, lo_n;
  logic sign_n;
  logic [9:0] dig_n;
  logic [7:0] addr;
  logic [31:0] wdata, rd_data;
  logic irq;
  logic [131:0] mat, exp_mat;
  logic [11:0] signs;
  logic prog, trk, gim, noatt, operr, temp, rstl, nav;
  logic [10:0] c;
  int errors, check_count, cycles;
  rwd_word_src src_u (.sys_clk_i(sys_clk_i), .word_i(word), .valid_i(valid),
    .row_hi_n_o(hi_n), .row_lo_n_o(lo_n), .sign_n_o(sign_n), .digit_n_o(dig_n));
  rwd_relay_decoder dut_u (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .row_code_input_high_n_i(hi_n), .row_code_input_low_n_i(lo_n),
    .sign_column_input_n_i(sign_n), .digit_column_n_i(dig_n), .lamp_reset_key_i(key),
    .lamp_reset_code_i(code_seen), .operator_error_req_i(err_req), .temp_req_i(temp_req),
    .restart_req_i(rst_req), .addr_i(addr), .wr_data_i(wdata), .wr_i(wr), .rd_i(rd),
    .rd_data_o(rd_data), .irq_o(irq), .relay_matrix_o(mat), .sign_relays_o(signs),
    .program_lamp_o(prog), .tracker_lamp_o(trk), .gimbal_lock_lamp_o(gim),
    .no_attitude_lamp_o(noatt), .operator_error_lamp_o(operr), .temp_lamp_o(temp),
    .restart_lamp_o(rstl), .navigation_caution_output_o(nav));
  // 100 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // hang guard
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1;
    `rwd_chk(rd_data, e)
  endtask : bus_rd
  // present a word long enough to pass the synchronisers, then idle
  task automatic send(input logic [3:0] code, input logic [10:0] cols);
    @(posedge sys_clk_i);
    word <= {code, cols};
    valid <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    valid <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    #1;
  endtask : send
  task automatic lamp_chk(input logic [7:0] e);
    `rwd_chk({prog, trk, gim, noatt, nav, operr, temp, rstl}, e)
  endtask : lamp_chk
  initial begin
    {resetn_i, valid, key, code_seen, err_req, temp_req, rst_req, wr, rd} = '0;
    word = '0;
    addr = '0;
    wdata = '0;
    exp_mat = '0;
    repeat (10) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    // reset values
    bus_rd(rwd_pkg::RWD_REG_CTRL, rwd_pkg::RWD_CTRL_RST);
    bus_rd(rwd_pkg::RWD_REG_MASK, rwd_pkg::RWD_MASK_RST);
    bus_rd(rwd_pkg::RWD_REG_STATUS, 32'h0000_0000);
    `rwd_chk(mat, exp_mat)
    // every digit row loads its columns, others keep theirs
    for (int i = 1; i <= 11; i++) begin
      c = 11'h2A5 ^ {7'h00, i[3:0]} ^ {i[3:0], 7'h00};
      send(i[3:0], c);
      exp_mat[(i - 1) * 11 +: 11] = c;
      `rwd_chk(mat, exp_mat)
      `rwd_chk(signs[i - 1], c[10])
      bus_rd(rwd_pkg::RWD_REG_DIGITS, {16'h0000, 4'(i - 1), 1'b0, c});
    end
    `rwd_chk(mat[10:0], 11'h2A4 ^ 11'h080)
    bus_rd(rwd_pkg::RWD_REG_STATUS, 32'h0000_0001);
    bus_wr(rwd_pkg::RWD_REG_STATUS, 32'h0000_0001);
    bus_rd(rwd_pkg::RWD_REG_STATUS, 32'h0000_0000);
    // rewrite of row 1 leaves all other rows latched
    send(4'h1, 11'h7FF);
    exp_mat[10:0] = 11'h7FF;
    `rwd_chk(mat, exp_mat)
    // all-zero row code selects nothing
    send(4'h0, 11'h3C3);
    `rwd_chk(mat, exp_mat)
    // unwired codes write nothing and flag
    for (int i = 13; i <= 15; i++) begin
      send(i[3:0], 11'h155);
      `rwd_chk(mat, exp_mat)
    end
    bus_rd(rwd_pkg::RWD_REG_STATUS, 32'h0000_0003);
    bus_wr(rwd_pkg::RWD_REG_STATUS, 32'h0000_0003);
    // updates disabled
    bus_wr(rwd_pkg::RWD_REG_CTRL, 32'h0000_0000);
    send(4'h2, 11'h000);
    `rwd_chk(mat, exp_mat)
    bus_wr(rwd_pkg::RWD_REG_CTRL, 32'h0000_0001);
    // masked update event raises the interrupt, clearing drops it
    bus_wr(rwd_pkg::RWD_REG_MASK, 32'h0000_0001);
    #1;
    `rwd_chk(irq, 1'b0)
    send(4'h2, 11'h000);
    exp_mat[21:11] = 11'h000;
    `rwd_chk(mat, exp_mat)
    `rwd_chk(irq, 1'b1)
    bus_wr(rwd_pkg::RWD_REG_STATUS, 32'h0000_0001);
    #1;
    `rwd_chk(irq, 1'b0)
    bus_wr(rwd_pkg::RWD_REG_MASK, 32'h0000_0000);
    // lamp row lights lamps and raises caution
    send(4'hC, 11'h1A8);
    exp_mat[131:121] = 11'h1A8;
    @(posedge sys_clk_i);
    #1;
    `rwd_chk(mat, exp_mat)
    lamp_chk(8'hF8);
    // hard-wired reset discrete clears cautions, not no-attitude
    key <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    key <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    #1;
    exp_mat[131:121] = 11'h008;
    `rwd_chk(mat, exp_mat)
    lamp_chk(8'h10);
    // status lamps follow requests, keycode reset clears them
    err_req <= 1'b1;
    temp_req <= 1'b1;
    rst_req <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    #1;
    lamp_chk(8'h17);
    code_seen <= 1'b1;
    @(posedge sys_clk_i);
    code_seen <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    #1;
    lamp_chk(8'h10);
    {err_req, temp_req, rst_req} <= 3'b000;
    repeat (2) @(posedge sys_clk_i);
    {err_req, temp_req, rst_req} <= 3'b111;
    repeat (4) @(posedge sys_clk_i);
    #1;
    lamp_chk(8'h17);
    bus_rd(rwd_pkg::RWD_REG_STATUS, 32'h0000_000D);
    // computer side of a keyed entry, shown on one digit row
    send(4'h9, 11'h000);
    exp_mat[98:88] = 11'h000;
    `rwd_chk(mat, exp_mat)
    send(4'h9, {1'b0, 5'h15, 5'h03});
    exp_mat[98:88] = {1'b0, 5'h15, 5'h03};
    `rwd_chk(mat, exp_mat)
    send(4'h9, 11'h000);
    `rwd_chk(mat[98:88], 11'h000)
    send(4'h9, {1'b1, 5'h15, 5'h03});
    exp_mat[98:88] = {1'b1, 5'h15, 5'h03};
    `rwd_chk(signs[8], 1'b1)
    `rwd_chk(mat, exp_mat)
    bus_rd(rwd_pkg::RWD_REG_ROW_BASE + 8'h20, {21'h0, exp_mat[98:88]});
    bus_rd(rwd_pkg::RWD_REG_ROW_BASE, {21'h0, exp_mat[10:0]});
    bus_rd(rwd_pkg::RWD_REG_WORD, 32'h0000_0000);
    // unmapped read answers zero
    bus_rd(8'h30, 32'h0000_0000);
    close_out();
  end
endmodule : tb_top
